// ===== verilog/dsa_pkg.sv
// Package for the delta-sigma decimator and conversion sequencer.
// Assumes a single 100 MHz core clock and a register port on the same clock.
package dsa_pkg;

    // Register offsets on the plain register port (byte addresses)
    localparam logic [3:0] DSA_REG_CTRL = 4'h0;
    localparam logic [3:0] DSA_REG_STAT = 4'h4;
    localparam logic [3:0] DSA_REG_MASK = 4'h8;
    localparam logic [3:0] DSA_REG_RES = 4'hC;

    // Control register fields
    localparam int DSA_CTRL_START = 0;
    localparam int DSA_CTRL_MODE_LO = 1;
    localparam int DSA_CTRL_RES_LO = 3;
    localparam int DSA_CTRL_EN = 5;

    // Status and mask bit positions
    localparam int DSA_ST_DONE = 0;
    localparam int DSA_ST_OVR = 1;
    localparam int DSA_ST_BUSY = 2;

    // Decimation ratio per resolution (modulator bits per conversion)
    localparam logic [15:0] DSA_OSR_8 = 16'h0010;
    localparam logic [15:0] DSA_OSR_12 = 16'h0040;
    localparam logic [15:0] DSA_OSR_16 = 16'h0100;
    localparam logic [15:0] DSA_OSR_20 = 16'h0400;
    localparam logic [15:0] DSA_OSR_20_TURBO = 16'h0100;

    // Conversions that only prime the filter before a valid result
    localparam logic [1:0] DSA_PRIME_CONV = 2'h3;

    // Width of the integrator chain: 4 * log2(max ratio) + 1
    localparam int DSA_ACC_W = 41;
    localparam int DSA_RES_W = 20;

    typedef enum logic [1:0] {
        DSA_MODE_SINGLE,
        DSA_MODE_CONT,
        DSA_MODE_MULTI,
        DSA_MODE_TURBO
    } dsa_mode_e;

    typedef enum logic [1:0] {
        DSA_BITS_8,
        DSA_BITS_12,
        DSA_BITS_16,
        DSA_BITS_20
    } dsa_bits_e;

    typedef enum {
        DSA_ST_IDLE,
        DSA_ST_RUN,
        DSA_ST_WAIT_READ
    } dsa_state_e;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dsa_req_s;

endpackage

// ===== verilog/dsa_seq.sv
// Delta-sigma decimator and conversion sequencer: sinc4 filter, four modes,
// result register, sticky status with interrupt.
// Assumes the modulator bit stream and its strobe come from another clock
// domain pin and are synchronised here; the register port is on core_clk_i.
//
// Behaviour
// - Resolution 8, 12, 16 or 20 bits is chosen, each with its own decimation ratio.
// - The one-bit modulator stream is decimated into a parallel result word.
// - The filter is four cascaded integrators followed by four combs (sinc4).
// - Each output word depends on the four latest conversion periods of the filter.
// - After an input switch, results are held invalid until the fourth conversion.
// - Four modes, each started by the start control bit or the trigger input.
// - Done status and done output stay set until the result is read.
// - Single mode waits for a trigger, runs four conversions, reports after the fourth.
// - Single mode returns to standby after the result is read and waits for a trigger.
// - Continuous mode primes for three conversions, then delivers every conversion.
// - Multi mode clears and re-primes the filter between samples.
// - Multi mode starts the next sample as soon as one is read out.
// - Turbo acts as multi up to 16 bits; at 20 bits it uses a quarter ratio, one reset.
`timescale 1ns/10ps
module dsa_seq
    import dsa_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Modulator stream, trigger and mux switch notice
    input wire logic mod_bit_i,
    input wire logic mod_stb_i,
    input wire logic soc_i,
    input wire logic mux_switch_i,
    // Status outputs
    output logic eoc_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic soc_prev_q;
    logic stb_prev_q;

    // All pins pass two flops; strobe and trigger edges also read a third flop
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            soc_prev_q <= 1'b0;
            stb_prev_q <= 1'b0;
        end else begin
            sync1_q <= {mux_switch_i, soc_i, mod_stb_i, mod_bit_i};
            sync2_q <= sync1_q;
            soc_prev_q <= sync2_q[2];
            stb_prev_q <= sync2_q[1];
        end
    end

    wire logic mod_bit = sync2_q[0];
    wire logic mod_tick = sync2_q[1] & ~stb_prev_q;
    wire logic soc_rise = sync2_q[2] & ~soc_prev_q;
    wire logic mux_sw = sync2_q[3];

    ////////////////////////////////////////////////////////////////////////////
    // Register port decode

    dsa_req_s req;
    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    logic [5:0] ctrl_q;
    logic [2:0] stat_q;
    logic [2:0] mask_q;
    logic [DSA_RES_W-1:0] res_q;

    wire logic wr_ctrl = req.wr && (req.addr == DSA_REG_CTRL);
    wire logic wr_mask = req.wr && (req.addr == DSA_REG_MASK);
    wire logic rd_stat = req.rd && (req.addr == DSA_REG_STAT);
    wire logic rd_res = req.rd && (req.addr == DSA_REG_RES);
    wire logic sw_start = wr_ctrl && req.wdata[DSA_CTRL_START];
    wire dsa_mode_e mode = dsa_mode_e'(ctrl_q[DSA_CTRL_MODE_LO +: 2]);
    wire dsa_bits_e bits = dsa_bits_e'(ctrl_q[DSA_CTRL_RES_LO +: 2]);
    wire logic enabled = ctrl_q[DSA_CTRL_EN];
    wire logic trigger = sw_start | soc_rise;

    // Decimation ratio for the chosen resolution and mode
    function automatic logic [15:0] osr_of(input dsa_bits_e b, input dsa_mode_e m);
        case (b)
            DSA_BITS_8: osr_of = DSA_OSR_8;
            DSA_BITS_12: osr_of = DSA_OSR_12;
            DSA_BITS_16: osr_of = DSA_OSR_16;
            default: osr_of = (m == DSA_MODE_TURBO) ? DSA_OSR_20_TURBO : DSA_OSR_20;
        endcase
    endfunction

    // Shift a filter output down to the result width for a resolution
    function automatic logic [DSA_RES_W-1:0] scale(input logic [DSA_ACC_W-1:0] v,
                                                   input dsa_bits_e b, input dsa_mode_e m);
        case (b)
            DSA_BITS_8: scale = {12'h000, v[16:9]};
            DSA_BITS_12: scale = {8'h00, v[24:13]};
            DSA_BITS_16: scale = {4'h0, v[32:17]};
            default: scale = (m == DSA_MODE_TURBO) ? v[32:13] : v[40:21];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Sinc4 decimator

    logic [DSA_ACC_W-1:0] integ_q [4];
    logic [DSA_ACC_W-1:0] comb_q [4];
    logic [DSA_ACC_W-1:0] comb_d [4];
    logic [15:0] phase_q;
    logic filt_clr;
    logic filt_run;

    wire logic [15:0] osr = osr_of(bits, mode);
    wire logic dump = filt_run && mod_tick && (phase_q == osr - 16'h0001);

    // Comb chain differences, evaluated at each dump
    always_comb begin
        comb_d[0] = integ_q[3] - comb_q[0];
        comb_d[1] = comb_d[0] - comb_q[1];
        comb_d[2] = comb_d[1] - comb_q[2];
        comb_d[3] = comb_d[2] - comb_q[3];
    end

    // Integrators run per modulator bit; combs hold the previous dump inputs
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            integ_q <= '{default: '0};
            comb_q <= '{default: '0};
            phase_q <= 16'h0000;
        end else if (filt_clr) begin
            integ_q <= '{default: '0};
            comb_q <= '{default: '0};
            phase_q <= 16'h0000;
        end else if (filt_run && mod_tick) begin
            integ_q[0] <= integ_q[0] + {{(DSA_ACC_W-1){1'b0}}, mod_bit};
            integ_q[1] <= integ_q[1] + integ_q[0];
            integ_q[2] <= integ_q[2] + integ_q[1];
            integ_q[3] <= integ_q[3] + integ_q[2];
            phase_q <= dump ? 16'h0000 : phase_q + 16'h0001;
            if (dump) begin
                comb_q[0] <= integ_q[3];
                comb_q[1] <= comb_d[0];
                comb_q[2] <= comb_d[1];
                comb_q[3] <= comb_d[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer

    dsa_state_e state_q;
    dsa_state_e state_d;
    logic [1:0] prime_q;
    logic [1:0] prime_d;
    logic deliver;
    wire logic primed = (prime_q == DSA_PRIME_CONV);
    wire logic res_read = rd_res && stat_q[DSA_ST_DONE];

    // Next state; triggers are only seen in standby
    always_comb begin
        state_d = state_q;
        prime_d = prime_q;
        filt_clr = 1'b0;
        filt_run = 1'b0;
        deliver = 1'b0;
        case (state_q)
            DSA_ST_IDLE: begin
                filt_clr = 1'b1;
                prime_d = 2'h0;
                if (enabled && trigger) begin
                    state_d = DSA_ST_RUN;
                end
            end
            DSA_ST_RUN: begin
                filt_run = 1'b1;
                if (mux_sw) begin
                    prime_d = 2'h0;
                end else if (dump) begin
                    if (!primed) begin
                        prime_d = prime_q + 2'h1;
                    end else begin
                        deliver = 1'b1;
                        if (mode != DSA_MODE_CONT) begin
                            state_d = DSA_ST_WAIT_READ;
                        end
                    end
                end
                if (!enabled) begin
                    state_d = DSA_ST_IDLE;
                end
            end
            DSA_ST_WAIT_READ: begin
                filt_clr = 1'b1;
                prime_d = 2'h0;
                if (res_read || !enabled) begin
                    if (enabled && (mode == DSA_MODE_MULTI || mode == DSA_MODE_TURBO)) begin
                        state_d = DSA_ST_RUN;
                    end else begin
                        state_d = DSA_ST_IDLE;
                    end
                end
            end
            default: state_d = DSA_ST_IDLE;
        endcase
    end

    // Sequencer state
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= DSA_ST_IDLE;
            prime_q <= 2'h0;
        end else begin
            state_q <= state_d;
            prime_q <= prime_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers, status and interrupt

    // Set wins over the read-clear so no conversion event is lost
    wire logic done_set = deliver;
    wire logic ovr_set = deliver && stat_q[DSA_ST_DONE] && !res_read;
    wire logic [2:0] stat_d = {state_q != DSA_ST_IDLE,
                               ovr_set | (stat_q[DSA_ST_OVR] & ~rd_stat),
                               done_set | (stat_q[DSA_ST_DONE] & ~res_read)};

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= 6'h00;
            mask_q <= 3'h0;
            stat_q <= 3'h0;
            res_q <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= {req.wdata[DSA_CTRL_EN:DSA_CTRL_MODE_LO], 1'b0};
            end
            if (wr_mask) begin
                mask_q <= req.wdata[2:0];
            end
            stat_q <= stat_d;
            if (deliver) begin
                res_q <= scale(comb_d[3], bits, mode);
            end
        end
    end

    // Read mux and registered outputs
    logic [31:0] rdata_d;
    always_comb begin
        case (req.addr)
            DSA_REG_CTRL: rdata_d = {26'h0, ctrl_q};
            DSA_REG_STAT: rdata_d = {29'h0, stat_q};
            DSA_REG_MASK: rdata_d = {29'h0, mask_q};
            DSA_REG_RES: rdata_d = {12'h000, res_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 32'h0000_0000;
            eoc_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            reg_rdata_o <= req.rd ? rdata_d : 32'h0000_0000;
            eoc_o <= stat_d[DSA_ST_DONE];
            irq_o <= |(stat_d[1:0] & mask_q[1:0]);
        end
    end

endmodule // dsa_seq

// ===== verif/dsa_seq_properties.sv
// Checker for dsa_seq: register port, done and interrupt outputs.
// Assumes it is bound to dsa_seq and sees only its ports.
`timescale 1ns/10ps
module dsa_seq_properties
    import dsa_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // Stream, trigger and outputs
    input wire logic mod_bit_i,
    input wire logic mod_stb_i,
    input wire logic soc_i,
    input wire logic mux_switch_i,
    input wire logic eoc_o,
    input wire logic irq_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Result read strobe, the only thing that may clear done
    wire logic rd_res = reg_rd_i && reg_addr_i == DSA_REG_RES;
    wire logic rd_st = reg_rd_i && reg_addr_i == DSA_REG_STAT;
    wire logic mask_op = reg_addr_i == DSA_REG_MASK;

    property p_idle; !$past(reg_rd_i) |-> reg_rdata_o == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data not zero");
    property p_hold; eoc_o && !rd_res && !$past(rd_res) && !reg_wr_i |=> eoc_o; endproperty
    a_hold: assert property (p_hold) else $error("done dropped unread");
    property p_clear; eoc_o && rd_res |-> ##2 !eoc_o; endproperty
    a_clear: assert property (p_clear) else $error("done not cleared");
    property p_unmap; $past(reg_rd_i) && $past(reg_addr_i[1:0]) != 2'h0 |-> reg_rdata_o == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_start; $past(reg_rd_i) && $past(reg_addr_i) == DSA_REG_CTRL
        |-> !reg_rdata_o[DSA_CTRL_START]; endproperty
    a_start: assert property (p_start) else $error("start bit reads one");
    property p_done; $past(rd_st) |-> reg_rdata_o[DSA_ST_DONE] == $past(eoc_o); endproperty
    a_done: assert property (p_done) else $error("done flag differs from output");
    property p_irq; $past(rd_st) && $past(irq_o) |-> reg_rdata_o[1:0] != 2'h0; endproperty
    a_irq: assert property (p_irq) else $error("interrupt without status");
    property p_mask; reg_wr_i && mask_op ##2 reg_rd_i && mask_op
        |=> reg_rdata_o[1:0] == $past(reg_wdata_i[1:0], 3); endproperty
    a_mask: assert property (p_mask) else $error("mask readback wrong");
    c_eoc: cover property ($rose(eoc_o));
    c_irq: cover property ($rose(irq_o));
    c_unmap: cover property (reg_rd_i && reg_addr_i == 4'h2);
endmodule // dsa_seq_properties
bind dsa_seq dsa_seq_properties u_dsa_seq_properties (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .mod_bit_i(mod_bit_i), .mod_stb_i(mod_stb_i), .soc_i(soc_i),
    .mux_switch_i(mux_switch_i), .eoc_o(eoc_o), .irq_o(irq_o));

// ===== verif/dsa_mod_model.sv
// Modulator stand-in: one-bit stream with a strobe, half density.
// Assumes the sequencer samples a bit on each strobe rise.
`timescale 1ns/10ps
module dsa_mod_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Stream toward the sequencer
    output logic mod_bit_o,
    output logic mod_stb_o
);
    logic [1:0] phase_q;
    // Four clocks a bit so each strobe level lasts two clocks
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_q <= 2'h0;
            mod_stb_o <= 1'b0;
            mod_bit_o <= 1'b0;
        end else begin
            phase_q <= phase_q + 2'h1;
            mod_stb_o <= phase_q[1];
            if (phase_q == 2'h3) begin
                mod_bit_o <= ~mod_bit_o;
            end
        end
    end
endmodule // dsa_mod_model

// ===== verif/tb_dsa_seq.sv
// Testbench for dsa_seq: register tasks, mode sequences, timing bounds.
// Assumes dsa_mod_model gives one modulator bit every four clocks.
`timescale 1ns/10ps
module tb_dsa_seq
    import dsa_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic soc = 1'b0;
    logic mux = 1'b0;
    logic [31:0] rdata;
    logic mbit;
    logic mstb;
    logic eoc;
    logic irq;
    logic [31:0] d;
    int n;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    always #5 core_clk_i = ~core_clk_i;
    dsa_seq u_dsa_seq (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .mod_bit_i(mbit), .mod_stb_i(mstb), .soc_i(soc), .mux_switch_i(mux),
        .eoc_o(eoc), .irq_o(irq));
    dsa_mod_model u_dsa_mod_model (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .mod_bit_o(mbit), .mod_stb_o(mstb));
    ////////////////////////////////////////////////////////////////
    // Bus tasks: strobes one cycle, read data taken in the next cycle
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge core_clk_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge core_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_i);
        rd <= 1'b0;
        @(negedge core_clk_i);
        v = rdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait; sampled mid-cycle so the edge updates have landed
    task automatic wait_eoc();
        n = 0;
        while (eoc !== 1'b1 && n < 8000) begin
            @(negedge core_clk_i);
            n++;
        end
        // A wait that runs out is a hang of the sequencer
        if (eoc !== 1'b1) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, eoc, 1'b1);
        end
    endtask
    task automatic summarize();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Hang guard, well above the roughly 7200 cycles the tests need
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rd_reg(DSA_REG_STAT, d);
        chk(d, 32'h0);
        rd_reg(4'h2, d);
        chk(d, 32'h0);
        $display("test reset done");
        // Single, 8 bits: four periods of 64 clocks before done
        wr_reg(DSA_REG_CTRL, 32'h20);
        wr_reg(DSA_REG_CTRL, 32'h21);
        wait_eoc();
        chk(32'(n >= 192 && n <= 400), 32'h1);
        wr_reg(DSA_REG_CTRL, 32'h21);
        rd_reg(DSA_REG_STAT, d);
        chk(d[0], 32'h1);
        rd_reg(DSA_REG_RES, d);
        chk(d[31:8], 32'h0);
        repeat (600) @(negedge core_clk_i);
        chk(eoc, 32'h0);
        $display("test single done");
        // Trigger pin, 12 bits: ratio 64, so over 768 clocks
        wr_reg(DSA_REG_CTRL, 32'h28);
        soc <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        soc <= 1'b0;
        wait_eoc();
        chk(32'(n >= 768 && n <= 1400), 32'h1);
        rd_reg(DSA_REG_RES, d);
        chk(d[31:12], 32'h0);
        $display("test trigger done");
        // Continuous, 8 bits: one period between results, overrun, mask
        wr_reg(DSA_REG_MASK, 32'h3);
        rd_reg(DSA_REG_MASK, d);
        chk(d, 32'h3);
        wr_reg(DSA_REG_CTRL, 32'h22);
        wr_reg(DSA_REG_CTRL, 32'h23);
        wait_eoc();
        rd_reg(DSA_REG_RES, d);
        wait_eoc();
        chk(32'(n <= 80), 32'h1);
        repeat (80) @(negedge core_clk_i);
        chk(irq, 32'h1);
        rd_reg(DSA_REG_STAT, d);
        chk(d[1], 32'h1);
        wr_reg(DSA_REG_MASK, 32'h0);
        repeat (2) @(negedge core_clk_i);
        chk(irq, 32'h0);
        // Input switch restarts priming: about four periods again
        @(posedge core_clk_i);
        mux <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        mux <= 1'b0;
        rd_reg(DSA_REG_RES, d);
        wait_eoc();
        chk(32'(n >= 150), 32'h1);
        wr_reg(DSA_REG_CTRL, 32'h0);
        rd_reg(DSA_REG_RES, d);
        $display("test continuous done");
        // Multi, 8 bits: restarts by itself and re-primes
        wr_reg(DSA_REG_CTRL, 32'h24);
        wr_reg(DSA_REG_CTRL, 32'h25);
        wait_eoc();
        rd_reg(DSA_REG_RES, d);
        wait_eoc();
        chk(32'(n >= 192 && n <= 400), 32'h1);
        wr_reg(DSA_REG_CTRL, 32'h0);
        rd_reg(DSA_REG_RES, d);
        $display("test multi done");
        // Turbo, 20 bits: ratio 256 instead of 1024
        wr_reg(DSA_REG_CTRL, 32'h3E);
        wr_reg(DSA_REG_CTRL, 32'h3F);
        wait_eoc();
        chk(32'(n >= 3072 && n <= 5000), 32'h1);
        rd_reg(DSA_REG_RES, d);
        chk(d[31:20], 32'h0);
        $display("test turbo done");
        summarize();
    end
endmodule // tb_dsa_seq
